// file: cache_err_pkg.sv
// Purpose: shared constants for the cache parity and fault handler
// Assumes: one clock, asynchronous active-high reset
// Notes:   operation kinds and response codes used by the handler ports
package cache_err_pkg;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WBUF_WRITE,
    OP_ALLOC,
    OP_CLEAN,
    OP_INV_ADDR,
    OP_INV_INDEX,
    OP_CLEAN_INV_ADDR,
    OP_CLEAN_INV_INDEX
  } op_kind_t;

  localparam logic [1:0] TRANS_IDLE = 2'h0;
  localparam logic [1:0] TRANS_BUSY = 2'h1;
  localparam logic [1:0] TRANS_NSEQ = 2'h2;
  localparam logic [1:0] TRANS_SEQ  = 2'h3;

  localparam logic [2:0] RESP_OKAY  = 3'h0;
  localparam logic [2:0] RESP_ERROR = 3'h1;

  localparam logic [1:0] SIZE_8  = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;
  localparam logic [1:0] SIZE_64 = 2'h3;

  localparam logic       READY_RESET = 1'b1;
  localparam logic [2:0] RESP_RESET  = 3'h0;

endpackage

// file: cache_parity_error_handler.sv
// Purpose: decides event pulses, slave responses and cache actions on faults
// Assumes: cache pipeline presents op kind, fault strobes and read words
// Notes:   all outputs registered; slave logic advances on port enable
`timescale 1ns/1ps

module cache_parity_error_handler #(
  parameter int DATA_W = 64,
  parameter int TAG_W  = 20
) (
  input  wire logic                  clk,                // system clock
  input  wire logic                  rst,                // async reset
  input  wire logic                  parity_enable,      // aux control bit
  input  wire logic                  slave_port_clock_enable, // port enable
  input  wire logic [1:0]            htrans,             // transfer type
  input  wire logic [2:0]            hsize,              // transfer size
  input  wire logic [DATA_W/8-1:0]   slave_byte_lane_strobes, // lanes
  input  wire logic                  slave_unaligned_flag,    // unaligned
  input  wire logic [3:0]            slave_sideband_attributes, // attrs
  input  wire logic                  op_valid,           // op step valid
  input  wire cache_err_pkg::op_kind_t op_kind,          // op kind
  input  wire logic                  op_write_back,      // write-back access
  input  wire logic                  op_busy,            // beat not ready
  input  wire logic                  op_last,            // last beat
  input  wire logic                  tag_lookup,         // tag read this cycle
  input  wire logic [TAG_W-1:0]      tag_rd,             // tag read word
  input  wire logic                  tag_rd_par,         // stored tag parity
  input  wire logic                  tag_rd_fault,       // tag RAM read fault
  input  wire logic                  tag_wr,             // tag write strobe
  input  wire logic                  tag_wr_fault,       // tag RAM write fault
  input  wire logic [TAG_W-1:0]      tag_wd,             // tag write word
  input  wire logic                  data_read,          // data read strobe
  input  wire logic [DATA_W-1:0]     data_rd,            // data read word
  input  wire logic [DATA_W/8-1:0]   data_rd_par,        // stored parity
  input  wire logic                  data_rd_fault,      // data RAM rd fault
  input  wire logic                  data_wr,            // data write strobe
  input  wire logic                  data_wr_fault,      // data RAM wr fault
  input  wire logic [DATA_W-1:0]     data_wd,            // data write word
  output logic [DATA_W-1:0]          slave_read_data,    // read data
  output logic                       hready,             // transfer ready
  output logic [2:0]                 hresp,              // response
  output logic [3:0]                 size_bytes_log2,    // decoded size
  output logic [DATA_W/8-1:0]        data_wr_par,        // byte parity
  output logic                       tag_wr_par,         // shared tag parity
  output logic                       tag_parity_event,   // tag parity pulse
  output logic                       tag_read_fault_event, // tag fault pulse
  output logic                       data_parity_event,  // data parity pulse
  output logic                       data_read_fault_event, // data rd pulse
  output logic                       data_write_fault_event, // data wr pulse
  output logic                       tag_write_fault_event, // tag wr pulse
  output logic                       cache_write_block,  // suppress write
  output logic                       mark_dirty,         // set line dirty
  output logic                       evict_drop,         // skip eviction
  output logic                       clean_abort,        // cancel clean
  output logic                       inv_cancel,         // cancel invalidate
  output logic                       inv_do              // invalidate line
);
  import cache_err_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // fault classification
  logic tag_par_err;
  logic data_par_err;
  logic tag_any;
  logic data_any;
  logic err_seen_r;

  function automatic logic [DATA_W/8-1:0] byte_par(
    input logic [DATA_W-1:0] d
  );
    logic [DATA_W/8-1:0] p;
    p = '0;
    for (int i = 0; i < DATA_W/8; i++) begin
      p[i] = ^d[i*8 +: 8];
    end
    return p;
  endfunction

  assign tag_par_err  = parity_enable & tag_lookup &
                        ((^tag_rd) != tag_rd_par);
  assign data_par_err = parity_enable & data_read &
                        (byte_par(data_rd) != data_rd_par);
  assign tag_any  = tag_par_err | (tag_lookup & tag_rd_fault);
  assign data_any = data_par_err | (data_read & data_rd_fault);

  ////////////////////////////////////////////////////////////////////////
  // event pulses, one cycle per detected fault
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tag_parity_event       <= 1'b0;
      tag_read_fault_event   <= 1'b0;
      data_parity_event      <= 1'b0;
      data_read_fault_event  <= 1'b0;
      data_write_fault_event <= 1'b0;
      tag_write_fault_event  <= 1'b0;
    end else begin
      tag_parity_event       <= op_valid & tag_par_err;
      tag_read_fault_event   <= op_valid & tag_lookup & tag_rd_fault;
      data_parity_event      <= op_valid & data_par_err;
      data_read_fault_event  <= op_valid & data_read & data_rd_fault;
      data_write_fault_event <= op_valid & data_wr & data_wr_fault;
      tag_write_fault_event  <= op_valid & tag_wr & tag_wr_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cache action controls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cache_write_block <= 1'b0;
      mark_dirty        <= 1'b0;
      evict_drop        <= 1'b0;
      clean_abort       <= 1'b0;
      inv_cancel        <= 1'b0;
      inv_do            <= 1'b0;
    end else begin
      cache_write_block <= op_valid & (op_kind == OP_WBUF_WRITE) &
                           tag_any;
      mark_dirty  <= op_valid & (op_kind == OP_WBUF_WRITE) & data_wr &
                     op_write_back & ~tag_any;
      // allocation keeps running; only the eviction is dropped
      evict_drop  <= op_valid & (op_kind == OP_ALLOC) & data_any;
      clean_abort <= op_valid & (tag_any | data_any) &
                     (op_kind == OP_CLEAN || op_kind == OP_CLEAN_INV_ADDR ||
                      op_kind == OP_CLEAN_INV_INDEX);
      inv_cancel  <= op_valid & ((op_kind == OP_INV_ADDR & tag_any) |
                     (op_kind == OP_CLEAN_INV_ADDR &
                      (tag_any | data_any)));
      inv_do      <= op_valid & (op_kind == OP_CLEAN_INV_INDEX);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parity generation for writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_wr_par <= '0;
      tag_wr_par  <= 1'b0;
    end else begin
      data_wr_par <= parity_enable ? byte_par(data_wd) : '0;
      tag_wr_par  <= parity_enable & (^tag_wd);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // slave port response, advanced only on port enable
  logic read_beat;
  logic read_err;
  assign read_beat = op_valid & (op_kind == OP_READ) &
                     ((htrans == TRANS_NSEQ) | (htrans == TRANS_SEQ));
  assign read_err  = read_beat & (tag_any | data_any | err_seen_r);

  // sticky across beats so the rest of the request answers error
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_seen_r <= 1'b0;
    end else if (slave_port_clock_enable) begin
      if (read_beat & ~op_busy & op_last) begin
        err_seen_r <= 1'b0;
      end else if (read_beat & (tag_any | data_any)) begin
        err_seen_r <= 1'b1;
      end
    end
  end

  // wait state while the current read beat is still busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hready <= READY_RESET;
    end else if (slave_port_clock_enable) begin
      hready <= ~(read_beat & op_busy);
    end
  end

  // error on every completed beat of a read request from the first faulty beat on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hresp <= RESP_RESET;
    end else if (slave_port_clock_enable) begin
      hresp <= (read_err & ~op_busy) ? RESP_ERROR : RESP_OKAY;
    end
  end

  // data word passes through; undefined after tag faults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slave_read_data <= '0;
    end else if (slave_port_clock_enable) begin
      slave_read_data <= data_rd;
    end
  end

  // size decode ignores the top size bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      size_bytes_log2 <= 4'h0;
    end else if (slave_port_clock_enable) begin
      unique case (hsize[1:0])
        SIZE_8:  size_bytes_log2 <= 4'h0;
        SIZE_16: size_bytes_log2 <= 4'h1;
        SIZE_32: size_bytes_log2 <= 4'h2;
        SIZE_64: size_bytes_log2 <= 4'h3;
      endcase
    end
  end

endmodule

// file: event_monitor_model.sv
// Purpose: event monitor stand-in
// Assumes: events are one-clock pulses
// Notes:   counts every pulse seen
`timescale 1ns/1ps
module event_monitor_model (
  input  wire logic       clk,  // clock
  input  wire logic       rst,  // reset
  input  wire logic [5:0] ev,   // event pulses
  output logic [7:0]      count // pulses so far
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) count <= 8'h00;
    else count <= count + 8'($countones(ev));
  end
endmodule

// file: cache_err_monitor.sv
// Purpose: port checker for the cache fault handler
// Assumes: outputs follow inputs by one clock
// Notes:   bound after endmodule
`timescale 1ns/1ps
module cache_err_monitor (
  input wire logic clk, rst, parity_enable, slave_port_clock_enable,
  input wire logic op_valid, op_busy, tag_lookup, tag_rd_fault, data_wr,
  input wire logic data_wr_fault, hready, tag_wr_par, tag_parity_event,
  input wire logic tag_read_fault_event, cache_write_block,
  input wire logic data_write_fault_event,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize, hresp,
  input wire logic [3:0] size_bytes_log2,
  input wire cache_err_pkg::op_kind_t op_kind
);
  import cache_err_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire tf = op_valid && tag_lookup && tag_rd_fault;
  wire rd = op_valid && op_kind == OP_READ && slave_port_clock_enable &&
            htrans[1];
  property p_tag_ev; tf |=> tag_read_fault_event; endproperty
  a_tag_ev: assert property (p_tag_ev) else $error("tag event");
  property p_err; rd && tf && !op_busy |=> hresp == RESP_ERROR; endproperty
  a_err: assert property (p_err) else $error("error resp");
  property p_wait; rd && op_busy |=> !hready; endproperty
  a_wait: assert property (p_wait) else $error("wait state");
  property p_block; tf && op_kind == OP_WBUF_WRITE |=> cache_write_block;
  endproperty
  a_block: assert property (p_block) else $error("write block");
  property p_dwr;
    op_valid && data_wr && data_wr_fault |=> data_write_fault_event;
  endproperty
  a_dwr: assert property (p_dwr) else $error("data wr event");
  property p_size;
    slave_port_clock_enable |=> size_bytes_log2 == 4'($past(hsize) & 3'h3);
  endproperty
  a_size: assert property (p_size) else $error("size decode");
  property p_hold;
    !slave_port_clock_enable |=> $stable(hresp) && $stable(size_bytes_log2);
  endproperty
  a_hold: assert property (p_hold) else $error("port hold");
  property p_par; !parity_enable |=> !tag_wr_par && !tag_parity_event;
  endproperty
  a_par: assert property (p_par) else $error("parity off");
endmodule

bind cache_parity_error_handler cache_err_monitor i_cache_err_monitor (.*);

// file: tb_cache_parity_error_handler.sv
// Purpose: self-checking bench for the cache fault handler
// Assumes: inputs change on the falling clock edge
// Notes:   event pulses also tallied by the monitor model
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
  error_cnt++; $display("unexpected %s exp %0h got %0h", n, e, a); end end
module tb_cache_parity_error_handler;
  import cache_err_pkg::*;
  logic clk = 0, rst = 1, parity_enable, slave_port_clock_enable, op_valid;
  logic op_write_back, op_busy, op_last, tag_lookup, tag_rd_par, tag_rd_fault;
  logic tag_wr, tag_wr_fault, data_read, data_rd_fault, data_wr, data_wr_fault;
  logic slave_unaligned_flag, hready, tag_wr_par, tag_parity_event, inv_do;
  logic tag_read_fault_event, data_parity_event, data_read_fault_event;
  logic data_write_fault_event, tag_write_fault_event, cache_write_block;
  logic mark_dirty, evict_drop, clean_abort, inv_cancel;
  logic [1:0] htrans;
  logic [2:0] hsize, hresp;
  logic [3:0] slave_sideband_attributes, size_bytes_log2;
  logic [7:0] slave_byte_lane_strobes, data_rd_par, data_wr_par, ev_count;
  logic [19:0] tag_rd, tag_wd;
  logic [63:0] data_rd, data_wd, slave_read_data;
  op_kind_t op_kind;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  always #20 clk = ~clk;
  cache_parity_error_handler i_cache_parity_error_handler (.*);
  event_monitor_model i_event_monitor_model (.clk(clk), .rst(rst),
    .ev({tag_parity_event, tag_read_fault_event, data_parity_event,
    data_read_fault_event, data_write_fault_event, tag_write_fault_event}),
    .count(ev_count));
  task automatic start(input op_kind_t k);
    {op_valid, op_write_back, op_busy, op_last, tag_lookup, tag_rd_fault} = '0;
    {tag_wr, tag_wr_fault, data_read, data_rd_fault, data_wr, data_wr_fault} = '0;
    {htrans, hsize, tag_rd, tag_rd_par, tag_wd, data_rd, data_rd_par} = '0;
    data_wd = '0;
    op_kind = k;
    op_valid = 1'b1;
  endtask
  task automatic t_read;
    int c0;
    c0 = ev_count;
    start(OP_READ);
    {htrans, tag_lookup, tag_rd_fault, op_busy} = {TRANS_NSEQ, 3'h7};
    @(negedge clk);
    `CHK("tag ev", 2'h2, {tag_read_fault_event, hready})
    start(OP_READ);
    {htrans, op_last, data_read, data_rd_fault} = {TRANS_SEQ, 3'h7};
    data_rd = 64'h3C3C5A5A0F0FA5A5;
    @(negedge clk);
    `CHK("rd ev", 2'h1, {tag_read_fault_event, data_read_fault_event})
    `CHK("rdata", 64'h3C3C5A5A0F0FA5A5, slave_read_data)
    `CHK("resp", RESP_ERROR, hresp)
    start(OP_READ);
    @(negedge clk);
    `CHK("count", 8'(c0 + 2), ev_count)
    $display("read faults done");
  endtask
  task automatic t_write;
    start(OP_WBUF_WRITE);
    {tag_lookup, tag_rd_fault} = 2'h3;
    @(negedge clk);
    `CHK("block", 1'b1, cache_write_block)
    start(OP_WBUF_WRITE);
    {op_write_back, data_wr, data_wr_fault} = 3'h7;
    @(negedge clk);
    `CHK("dirty", 2'h3, {data_write_fault_event, mark_dirty})
    start(OP_ALLOC);
    {tag_lookup, tag_rd_fault, data_read, data_rd_fault} = 4'hF;
    {tag_wr, tag_wr_fault, data_wr, data_wr_fault} = 4'hF;
    @(negedge clk);
    `CHK("alloc", 3'h6, {evict_drop, tag_write_fault_event, mark_dirty})
    $display("write and allocation done");
  endtask
  task automatic t_maint;
    op_kind_t k[4] = '{OP_CLEAN, OP_INV_ADDR, OP_CLEAN_INV_ADDR,
      OP_CLEAN_INV_INDEX};
    logic [2:0] e[4] = '{3'h4, 3'h2, 3'h6, 3'h5};
    foreach (k[i]) begin
      start(k[i]);
      {tag_lookup, tag_rd_fault} = 2'h3;
      @(negedge clk);
      `CHK("maint", e[i], {clean_abort, inv_cancel, inv_do})
    end
    start(OP_INV_INDEX);
    {tag_wr, tag_wr_fault} = 2'h3;
    @(negedge clk);
    `CHK("inv wr", 2'h2, {tag_write_fault_event, inv_do})
    $display("maintenance done");
  endtask
  task automatic t_port;
    logic [10:0] got;
    for (int i = 0; i < 8; i++) begin
      start(OP_READ);
      hsize = 3'(i);
      @(negedge clk);
      `CHK("size", 4'(i % 4), size_bytes_log2)
    end
    {slave_port_clock_enable, hsize} = 4'h0;
    @(negedge clk);
    `CHK("hold", 4'h3, size_bytes_log2)
    slave_port_clock_enable = 1'b1;
    for (int p = 1; p >= 0; p--) begin
      parity_enable = 1'(p);
      start(OP_READ);
      {tag_lookup, op_last, tag_rd, tag_wd} = {2'h3, 20'h1, 20'h7};
      data_wd = 64'h0301;
      {data_read, data_rd} = {1'b1, 64'h1};
      @(negedge clk);
      got = {data_parity_event, tag_parity_event, tag_wr_par, data_wr_par};
      `CHK("par", p ? 11'h701 : 11'h0, got)
    end
    $display("port control done");
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 400) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    {slave_byte_lane_strobes, slave_unaligned_flag} = '0;
    slave_sideband_attributes = '0;
    {parity_enable, slave_port_clock_enable} = 2'h3;
    start(OP_READ);
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_read();
    t_write();
    t_maint();
    t_port();
    complete_run();
  end
endmodule
